// File: core/aro_pkg.sv
`default_nettype none
package aro_pkg;
    // ------------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------------
    localparam int unsigned INSN_W       = 12;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned ADDR_W       = 5;
    localparam int unsigned SLOT_COUNT   = 32;
    localparam int unsigned OPC_HI       = 11;
    localparam int unsigned OPC_LO       = 6;
    localparam int unsigned DEST_BIT     = 5;
    localparam int unsigned ADDR_HI      = 4;
    localparam int unsigned NIBBLE_W     = 4;
    localparam logic [5:0]  OPC_ADD      = 6'h07;  // 000111
    localparam logic [5:0]  OPC_AND      = 6'h05;  // 000101
    localparam logic        DEST_ACC     = 1'h0;
    localparam logic        DEST_SLOT    = 1'h1;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACC_RST      = 8'h00;
    localparam logic [7:0]  SLOT_RST     = 8'h00;
    localparam logic        FLAG_RST     = 1'h0;

    typedef enum logic [1:0] {
        ARO_OP_NONE = 2'b00,
        ARO_OP_ADD  = 2'b01,
        ARO_OP_AND  = 2'b10
    } aro_op_t;
endpackage : aro_pkg
`default_nettype wire

// File: core/aro_decode.sv
`default_nettype none
// --------------------------------------------------------------------------
// instruction decoder
// --------------------------------------------------------------------------
module aro_decode (
    input  wire logic [11:0]     insn_i,
    input  wire logic            insn_valid_i,
    output var aro_pkg::aro_op_t op_o,
    output logic                 dest_slot_o,
    output logic [4:0]           addr_o
);
    // opcode match on the upper six bits
    always_comb begin
        unique case (insn_i[aro_pkg::OPC_HI:aro_pkg::OPC_LO])
            aro_pkg::OPC_ADD: op_o = aro_pkg::ARO_OP_ADD;
            aro_pkg::OPC_AND: op_o = aro_pkg::ARO_OP_AND;
            default:          op_o = aro_pkg::ARO_OP_NONE;
        endcase
        if (!insn_valid_i) begin
            op_o = aro_pkg::ARO_OP_NONE;
        end
    end
    // target bit and five-bit slot address
    assign dest_slot_o = insn_i[aro_pkg::DEST_BIT];
    assign addr_o      = insn_i[aro_pkg::ADDR_HI:0];
endmodule : aro_decode
`default_nettype wire

// File: core/aro_top.sv
`default_nettype none
module aro_top (
    input  wire logic            sys_clk_i,
    input  wire logic            arst_n_i,
    input  wire logic [11:0]     insn_i,
    input  wire logic            insn_valid_i,
    input  wire logic            acc_load_i,
    input  wire logic [7:0]      acc_load_data_i,
    input  wire logic [4:0]      peek_addr_i,
    output logic [7:0]           acc_o,
    output logic [7:0]           peek_data_o,
    output logic                 carry_flag_o,
    output logic                 nibble_overflow_flag_o,
    output logic                 zero_flag_o,
    output logic                 insn_done_o
);
    // ----------------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------------
    // only the second stage is read by the rest of the block
    logic rst_meta_q;
    logic rst_n_q;

    // two-stage release of the asynchronous reset; entry stays immediate,
    // while the release lands on a clock edge so that no register leaves
    // reset between edges and a cycle before its neighbours
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_q <= 1'h0;
            rst_n_q    <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------------
    // decode and operand fetch
    // ----------------------------------------------------------------------
    // datapath nets and state
    aro_pkg::aro_op_t op;                    // decoded operation, none when idle
    logic             dest_slot;             // result target bit
    logic [4:0]       addr;                  // operand slot address
    logic [7:0]       acc_q;                 // accumulator
    logic [7:0]       slot_q [aro_pkg::SLOT_COUNT];
    logic [7:0]       operand;               // addressed slot as read this cycle
    logic [8:0]       sum;                   // byte sum, carry out on top
    logic [4:0]       nib_sum;               // low nibble sum, nibble carry on top
    logic [7:0]       result;                // value to be written back
    logic             acc_wr;                // accumulator takes the result
    logic             slot_wr;               // addressed slot takes the result

    // opcode, target bit and slot address split off in a small decoder;
    // a word with the valid line low decodes as no operation at all,
    // so an idle fetch bus cannot disturb the datapath
    aro_decode u_decode (
        .insn_i       (insn_i),
        .insn_valid_i (insn_valid_i),
        .op_o         (op),
        .dest_slot_o  (dest_slot),
        .addr_o       (addr)
    );

    // ----------------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------------
    // zero test shared by both operations
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction : is_zero

    // true for any word that the decoder recognised
    function automatic logic is_alu_op(input aro_pkg::aro_op_t o);
        is_alu_op = (o != aro_pkg::ARO_OP_NONE);
    endfunction : is_alu_op

    // low nibble of a byte, widened by one bit to hold the nibble carry
    function automatic logic [4:0] low_nibble(input logic [7:0] v);
        low_nibble = {1'b0, v[3:0]};
    endfunction : low_nibble

    // ----------------------------------------------------------------------
    // operand read and compute
    // ----------------------------------------------------------------------

    // combinational read, compute in the same cycle; the slot array is read
    // without a register so that read, compute and write-back share one edge,
    // and a word that names the slot just written sees the new value
    always_comb begin
        operand = slot_q[addr];
        sum     = {1'b0, acc_q} + {1'b0, operand};
        nib_sum = low_nibble(acc_q) + low_nibble(operand);
        if (op == aro_pkg::ARO_OP_AND) begin
            result = acc_q & operand;
        end else begin
            result = sum[7:0];
        end
    end

    // ----------------------------------------------------------------------
    // write-back
    // ----------------------------------------------------------------------
    // write enables, decoded once and shared by the two writers
    assign acc_wr  = is_alu_op(op) && (dest_slot == aro_pkg::DEST_ACC);
    assign slot_wr = is_alu_op(op) && (dest_slot == aro_pkg::DEST_SLOT);

    // accumulator: result when target bit is 0; an external load only
    // wins when no instruction claims the accumulator in that cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_q <= aro_pkg::ACC_RST;
        end else if (acc_wr) begin
            acc_q <= result;
        end else if (acc_load_i) begin
            acc_q <= acc_load_data_i;                               // setup load
        end
    end

    // file register slots; result goes back when target bit is 1, and
    // every other slot keeps its contents
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < aro_pkg::SLOT_COUNT; i++) begin
                slot_q[i] <= aro_pkg::SLOT_RST;
            end
        end else if (slot_wr) begin
            slot_q[addr] <= result;
        end
    end

    // ----------------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------------
    // flag registers; the flag outputs follow them directly
    logic c_q;
    logic dc_q;
    logic z_q;

    // carry follows the top bit of the byte sum; only an add moves it,
    // so an AND in between leaves the last carry standing
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            c_q <= aro_pkg::FLAG_RST;
        end else if (op == aro_pkg::ARO_OP_ADD) begin
            c_q <= sum[aro_pkg::DATA_W];
        end
    end

    // nibble overflow follows the carry out of the low four bits, on add
    // only, at the same edge as the carry
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dc_q <= aro_pkg::FLAG_RST;
        end else if (op == aro_pkg::ARO_OP_ADD) begin
            dc_q <= nib_sum[aro_pkg::NIBBLE_W];
        end
    end

    // zero follows the written result for both operations; AND leaves the
    // other two flags as they were
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            z_q <= aro_pkg::FLAG_RST;
        end else begin
            // no operation and the unused code leave the flag as it was
            unique case (op)
                aro_pkg::ARO_OP_ADD: begin
                    z_q <= is_zero(result);
                end
                aro_pkg::ARO_OP_AND: begin
                    z_q <= is_zero(result);
                end
                aro_pkg::ARO_OP_NONE: begin
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // completion and observation
    // ----------------------------------------------------------------------
    // one-cycle completion strobe, raised by the edge that did the
    // write-back, so it stands together with the new accumulator and flags
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            insn_done_o <= 1'h0;
        end else begin
            insn_done_o <= is_alu_op(op);
        end
    end

    // registered observation of a slot; shows the array one edge late, so a
    // slot written at some edge appears here one cycle after that
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            peek_data_o <= aro_pkg::SLOT_RST;
        end else begin
            peek_data_o <= slot_q[peek_addr_i];
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    // accumulator and status leave straight from their registers, with no
    // logic between flip-flop and pin
    assign acc_o                  = acc_q;
    assign carry_flag_o           = c_q;
    assign nibble_overflow_flag_o = dc_q;
    assign zero_flag_o            = z_q;
endmodule : aro_top
`default_nettype wire

// File: tb/aro_top_assertions.sv
`default_nettype none
module aro_top_assertions (
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic [11:0] insn_i,
    input wire logic        insn_valid_i,
    input wire logic        acc_load_i,
    input wire logic [7:0]  acc_o,
    input wire logic        carry_flag_o,
    input wire logic        nibble_overflow_flag_o,
    input wire logic        zero_flag_o,
    input wire logic        insn_done_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // recognised word: opcode 000111 or 000101
    wire logic take = insn_valid_i && insn_i[11:8] == 4'h1 && insn_i[6];
    sequence s_add; insn_valid_i && insn_i[11:6] == 6'h07; endsequence
    sequence s_and; insn_valid_i && insn_i[11:6] == 6'h05; endsequence
    property p_done; (s_add or s_and) |=> insn_done_o; endproperty
    a_done: assert property (p_done) else $error("no done pulse");
    property p_idle; !take |=> !insn_done_o; endproperty
    a_idle: assert property (p_idle) else $error("stray done pulse");
    property p_and_flags;
        s_and |=> $stable(carry_flag_o) && $stable(nibble_overflow_flag_o);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and moved c or dc");
    property p_and_acc;
        s_and ##0 !insn_i[5] |=> (acc_o & ~$past(acc_o)) == 8'h00
            && zero_flag_o == (acc_o == 8'h00);
    endproperty
    a_and_acc: assert property (p_and_acc) else $error("and result wrong");
    property p_add_zero; s_add ##0 !insn_i[5] |=> zero_flag_o == (acc_o == 8'h00); endproperty
    a_add_zero: assert property (p_add_zero) else $error("add zero flag");
    property p_add_from0;
        s_add ##0 (!insn_i[5] && acc_o == 8'h00) |=> !carry_flag_o && !nibble_overflow_flag_o;
    endproperty
    a_add_from0: assert property (p_add_from0) else $error("add carry from zero");
    property p_slot_keep; take && insn_i[5] && !acc_load_i |=> $stable(acc_o); endproperty
    a_slot_keep: assert property (p_slot_keep) else $error("slot write hit acc");
    property p_refused;
        !take && !acc_load_i |=> $stable(acc_o) && $stable(zero_flag_o) && $stable(carry_flag_o);
    endproperty
    a_refused: assert property (p_refused) else $error("ignored word acted");
endmodule : aro_top_assertions
bind aro_top aro_top_assertions u_aro_chk (.sys_clk_i, .arst_n_i, .insn_i, .insn_valid_i,
    .acc_load_i, .acc_o, .carry_flag_o, .nibble_overflow_flag_o, .zero_flag_o, .insn_done_o);
`default_nettype wire

// File: tb/aro_fetch_model.sv
`default_nettype none
module aro_fetch_model (
    input  wire logic        sys_clk_i,
    input  wire logic        issue_i,
    input  wire logic [1:0]  kind_i,
    input  wire logic        dest_i,
    input  wire logic [4:0]  addr_i,
    output logic      [11:0] insn_o,
    output logic             valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] last_q = 12'h000;
    // encode add, and or an unknown opcode; idle bus shows the inverse of the last word
    always_comb begin
        valid_o = issue_i;
        insn_o = ~last_q;
        if (issue_i)
            insn_o = {kind_i == 0 ? 6'h07 : kind_i == 1 ? 6'h05 : 6'h06, dest_i, addr_i};
    end
    // remember the word last issued
    always @(posedge sys_clk_i) if (issue_i) last_q <= insn_o;
endmodule : aro_fetch_model
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 0, arst_n_i = 0, acc_load_i = 0, issue = 0, dest = 0, e_c = 0, e_dc = 0;
    logic e_z = 0, insn_valid_i, carry_flag_o, nibble_overflow_flag_o, zero_flag_o, insn_done_o;
    logic [1:0]  kind = 0;
    logic [4:0]  addr = 0, peek_addr_i = 0;
    logic [7:0]  acc_load_data_i = 0, acc_o, peek_data_o, e_acc = 0, e_slot [32];
    logic [11:0] insn_i;
    logic [31:0] r;
    int fail_count = 0, num_checks = 0, seed = 32'hc6d2, cyc = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    aro_top uut (.sys_clk_i, .arst_n_i, .insn_i, .insn_valid_i, .acc_load_i, .acc_load_data_i,
        .peek_addr_i, .acc_o, .peek_data_o, .carry_flag_o, .nibble_overflow_flag_o,
        .zero_flag_o, .insn_done_o);
    aro_fetch_model fm (.sys_clk_i, .issue_i(issue), .kind_i(kind), .dest_i(dest),
        .addr_i(addr), .insn_o(insn_i), .valid_o(insn_valid_i));
    task automatic summarize;
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one cycle: kind 0 add, 1 and, 2 unknown opcode, 3 no word
    task automatic step(input logic [1:0] k, input logic d, input logic [4:0] a,
                        input logic ld, input logic [7:0] v);
        logic [8:0] s;
        logic [7:0] q;
        issue = (k != 3); kind = k; dest = d; addr = a; acc_load_i = ld && k > 1;
        acc_load_data_i = v;
        q = e_acc & e_slot[a];
        if (k == 0) begin
            s = {1'b0, e_acc} + e_slot[a];
            q = s[7:0]; e_c = s[8]; e_dc = ({1'b0, e_acc[3:0]} + e_slot[a][3:0]) > 15;
        end
        if (k < 2) e_z = (q == 8'h00);
        if (k < 2 && d) e_slot[a] = q;
        else if (k < 2) e_acc = q;
        else if (ld) e_acc = v;
        @(posedge sys_clk_i) #1;
        chk(acc_o, e_acc);
        chk({4'h0, carry_flag_o, nibble_overflow_flag_o, zero_flag_o, insn_done_o},
            {4'h0, e_c, e_dc, e_z, k < 2});
    endtask : step
    always @(posedge sys_clk_i) if (++cyc > 2000) begin fail_count++; summarize; end
    initial begin
        for (int i = 0; i < 32; i++) e_slot[i] = 8'h00;
        repeat (20) @(posedge sys_clk_i);
        #1 arst_n_i = 1;
        repeat (3) @(posedge sys_clk_i);
        #1 step(0, 0, 0, 0, 0);
        // fill every slot through add write-back, highest address included
        for (int i = 0; i < 32; i++) begin
            step(3, 0, 0, 1, 8'hF9 - 8'(i * 7));
            step(0, 1, i[4:0], 0, 0);
        end
        repeat (400) begin
            r = $random(seed);
            step(r[1:0], r[2], r[7:3], r[8], r[23:16]);
        end
        step(3, 0, 0, 0, 0);
        for (int i = 0; i < 32; i++) begin
            peek_addr_i = i[4:0];
            repeat (2) @(posedge sys_clk_i);
            #1 chk(peek_data_o, e_slot[i]);
        end
        summarize;
    end
endmodule : testbench
`default_nettype wire
